//--- core/ifd_pkg.sv
// What this block does
// - primary opcode comes from instruction bits 0-5, bit 0 most significant.
// - bit 31 is the record flag except in branch, D-form and compare words; 1 updates condition register, 0 does not.
// - absolute target flag 0 adds offset to instruction address, 1 uses it directly.
// - link save flag 1 requests next sequential address into the link register.
// - 16-bit D-form displacement is sign-extended to 32 bits.
// - 24-bit branch offset gets two zero bits, then sign-extends to 32 bits.
// - conditional branches take their displacement from a 14-bit field.
// - overflow-enable bit of XO-form arithmetic requests exception register overflow update.
// - compare target field selects condition register field 0 to 7.
// - multiplies: 31/11 high unsigned, 31/235 low word, primary 07 immediate.
// - X-form logicals under 31: 444 or, 412 or-complement, 316 xor.
// - D-form logical immediates: 24 or, 26 xor, 27 xor shifted.
// - M-form rotates: 20 mask insert, 21 immediate mask, 23 register mask.
// - rotates pass mask start and stop bit numbers to the mask generator.
// - subtracts: 31/08 carrying, 31/136 extended, D-form primary 08 immediate.
// - word trap is 31/04, trap with immediate is D-form primary 03.
// - under 31: 598 synchronize, 306 buffer invalidate, 150 store conditional.
// - byte stores: primary 38, 31/215 indexed, 31/247 indexed with update.
// - XO-form under 31: 104 negate, 488 negative absolute value.
// - double float store 54, with update 55, indexed with update 31/759.
package ifd_pkg;

    // field positions, little-endian index of the lowest bit in the word
    localparam int PRIM_LSB   = 26;
    localparam int RT_LSB     = 21;
    localparam int RA_LSB     = 16;
    localparam int RB_LSB     = 11;
    localparam int XEXT_LSB   = 1;
    localparam int OE_POS     = 10;
    localparam int REC_POS    = 0;
    localparam int LINK_POS   = 0;
    localparam int ABS_POS    = 1;
    localparam int BOFF_LSB   = 2;
    localparam int CDISP_LSB  = 2;
    localparam int MSTART_LSB = 6;
    localparam int MSTOP_LSB  = 1;
    localparam int CRF_LSB    = 23;
    localparam int CMPW_POS   = 21;

    // primary opcodes
    localparam logic [5:0] PO_TWI    = 6'h03;
    localparam logic [5:0] PO_MULI   = 6'h07;
    localparam logic [5:0] PO_SUBI   = 6'h08;
    localparam logic [5:0] PO_CMPLI  = 6'h0a;
    localparam logic [5:0] PO_CMPI   = 6'h0b;
    localparam logic [5:0] PO_BCOND  = 6'h10;
    localparam logic [5:0] PO_BRANCH = 6'h12;
    localparam logic [5:0] PO_RLIMI  = 6'h14;
    localparam logic [5:0] PO_RLINM  = 6'h15;
    localparam logic [5:0] PO_RLNM   = 6'h17;
    localparam logic [5:0] PO_ORI    = 6'h18;
    localparam logic [5:0] PO_XORI   = 6'h1a;
    localparam logic [5:0] PO_XORIS  = 6'h1b;
    localparam logic [5:0] PO_EXT    = 6'h1f;
    localparam logic [5:0] PO_STB    = 6'h26;
    localparam logic [5:0] PO_STFD   = 6'h36;
    localparam logic [5:0] PO_STFDU  = 6'h37;

    // X-form extended opcodes, 10 bits
    localparam logic [9:0] XO_CMP    = 10'h000;
    localparam logic [9:0] XO_TW     = 10'h004;
    localparam logic [9:0] XO_CMPL   = 10'h020;
    localparam logic [9:0] XO_STWC   = 10'h096;
    localparam logic [9:0] XO_STBX   = 10'h0d7;
    localparam logic [9:0] XO_STBUX  = 10'h0f7;
    localparam logic [9:0] XO_TLBI   = 10'h132;
    localparam logic [9:0] XO_XOR    = 10'h13c;
    localparam logic [9:0] XO_ORC    = 10'h19c;
    localparam logic [9:0] XO_OR     = 10'h1bc;
    localparam logic [9:0] XO_SYNC   = 10'h256;
    localparam logic [9:0] XO_STFDUX = 10'h2f7;

    // XO-form extended opcodes, 9 bits below the overflow-enable bit
    localparam logic [8:0] XOO_SUBFC = 9'h008;
    localparam logic [8:0] XOO_MULHU = 9'h00b;
    localparam logic [8:0] XOO_NEG   = 9'h068;
    localparam logic [8:0] XOO_SUBFE = 9'h088;
    localparam logic [8:0] XOO_MULLW = 9'h0eb;
    localparam logic [8:0] XOO_NABS  = 9'h1e8;

    // register map, byte offsets
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_STATUS = 8'h04;
    localparam logic [7:0]  REG_COUNT  = 8'h08;
    localparam logic [7:0]  REG_LAST   = 8'h0c;
    localparam logic [1:0]  CTRL_RESET = 2'h1;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_FLUSH = 1;
    localparam logic [31:0] LINK_STEP  = 32'h00000004;

    typedef enum logic [5:0] {
        CL_ILLEGAL = 6'h00, CL_MULHU  = 6'h01, CL_MULLW  = 6'h02, CL_MULI   = 6'h03,
        CL_OR      = 6'h04, CL_ORC    = 6'h05, CL_XOR    = 6'h06, CL_ORI    = 6'h07,
        CL_XORI    = 6'h08, CL_XORIS  = 6'h09, CL_RLIMI  = 6'h0a, CL_RLINM  = 6'h0b,
        CL_RLNM    = 6'h0c, CL_SUBFC  = 6'h0d, CL_SUBFE  = 6'h0e, CL_SUBI   = 6'h0f,
        CL_TW      = 6'h10, CL_TWI    = 6'h11, CL_SYNC   = 6'h12, CL_TLBI   = 6'h13,
        CL_STWC    = 6'h14, CL_STB    = 6'h15, CL_STBX   = 6'h16, CL_STBUX  = 6'h17,
        CL_NEG     = 6'h18, CL_NABS   = 6'h19, CL_STFD   = 6'h1a, CL_STFDU  = 6'h1b,
        CL_STFDUX  = 6'h1c, CL_BRANCH = 6'h1d, CL_BCOND  = 6'h1e, CL_CMP    = 6'h1f,
        CL_CMPL    = 6'h20, CL_CMPI   = 6'h21, CL_CMPLI  = 6'h22
    } ifd_class_t;

endpackage

//--- core/ifd_decoder.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
module ifd_decoder #(
    parameter int COUNT_W = 16
) (
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // fetch side
    input  wire logic                 instrValid,
    input  wire logic [31:0]          instr,
    input  wire logic [31:0]          instrAddr,
    // decoded outputs
    output logic                      decValid,
    output logic                      decIllegal,
    output ifd_pkg::ifd_class_t       decClass,
    output logic [5:0]                primaryOp,
    output logic [9:0]                extOp,
    output logic [4:0]                rtSel,
    output logic [4:0]                raSel,
    output logic [4:0]                rbSel,
    output logic [31:0]               dispExt,
    output logic [31:0]               branchTarget,
    output logic                      absoluteTargetFlag,
    output logic                      linkWrite,
    output logic [31:0]               linkAddr,
    output logic                      recordEn,
    output logic                      ovEnable,
    output logic [2:0]                compareTargetCrField,
    output logic [4:0]                maskStartBit,
    output logic [4:0]                maskStopBit,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata
);
    import ifd_pkg::*;

    generate
        if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
            $error("COUNT_W must be 1 to 32");
        end
    endgenerate

    typedef struct packed {
        logic               hreadyout;
        logic               hresp;
        logic [31:0]        hrdata;
        logic               wrPend;
        logic [7:0]         wrAddr;
        logic [1:0]         ctrl;
        logic [COUNT_W-1:0] illegalCount;
        logic [31:0]        lastInstr;
        logic               decValid;
        logic               decIllegal;
        ifd_class_t         decClass;
        logic [5:0]         primaryOp;
        logic [9:0]         extOp;
        logic [4:0]         rtSel;
        logic [4:0]         raSel;
        logic [4:0]         rbSel;
        logic [31:0]        dispExt;
        logic [31:0]        branchTarget;
        logic               absoluteTargetFlag;
        logic               linkWrite;
        logic [31:0]        linkAddr;
        logic               recordEn;
        logic               ovEnable;
        logic [2:0]         compareTargetCrField;
        logic [4:0]         maskStartBit;
        logic [4:0]         maskStopBit;
    } ifd_state_t;

    ifd_state_t stateReg;
    ifd_state_t stateNext;

    // class lookup from primary and extended opcode
    function automatic ifd_class_t classOf(input logic [31:0] word);
        logic [5:0] po;
        logic [9:0] x10;
        logic [8:0] x9;
        ifd_class_t cls;
        po  = word[PRIM_LSB +: 6];
        x10 = word[XEXT_LSB +: 10];
        x9  = word[XEXT_LSB +: 9];
        cls = CL_ILLEGAL;
        case (po)
            PO_TWI: cls = CL_TWI;
            PO_MULI: cls = CL_MULI;
            PO_SUBI: cls = CL_SUBI;
            PO_CMPLI: cls = CL_CMPLI;
            PO_CMPI: cls = CL_CMPI;
            PO_BCOND: cls = CL_BCOND;
            PO_BRANCH: cls = CL_BRANCH;
            PO_RLIMI: cls = CL_RLIMI;
            PO_RLINM: cls = CL_RLINM;
            PO_RLNM: cls = CL_RLNM;
            PO_ORI: cls = CL_ORI;
            PO_XORI: cls = CL_XORI;
            PO_XORIS: cls = CL_XORIS;
            PO_STB: cls = CL_STB;
            PO_STFD: cls = CL_STFD;
            PO_STFDU: cls = CL_STFDU;
            PO_EXT: begin
                // full 10-bit match first: 759 and 247 share their low nine bits
                case (x10)
                    XO_CMP: cls = CL_CMP;
                    XO_CMPL: cls = CL_CMPL;
                    XO_TW: cls = CL_TW;
                    XO_STWC: cls = CL_STWC;
                    XO_SYNC: cls = CL_SYNC;
                    XO_TLBI: cls = CL_TLBI;
                    XO_STBX: cls = CL_STBX;
                    XO_STBUX: cls = CL_STBUX;
                    XO_STFDUX: cls = CL_STFDUX;
                    XO_OR: cls = CL_OR;
                    XO_ORC: cls = CL_ORC;
                    XO_XOR: cls = CL_XOR;
                    default: begin
                        case (x9)
                            XOO_MULHU: cls = CL_MULHU;
                            XOO_MULLW: cls = CL_MULLW;
                            XOO_SUBFC: cls = CL_SUBFC;
                            XOO_SUBFE: cls = CL_SUBFE;
                            XOO_NEG: cls = CL_NEG;
                            XOO_NABS: cls = CL_NABS;
                            default: cls = CL_ILLEGAL;
                        endcase
                    end
                endcase
            end
            default: cls = CL_ILLEGAL;
        endcase
        // a set width-select bit would ask for 64-bit compares, which this core lacks
        if ((cls == CL_CMP || cls == CL_CMPL || cls == CL_CMPI || cls == CL_CMPLI) &&
            word[CMPW_POS]) begin
            cls = CL_ILLEGAL;
        end
        return cls;
    endfunction

    // register read mux, sampled in the address phase
    function automatic logic [31:0] readMux(input ifd_state_t s, input logic [7:0] addr);
        logic [31:0] d;
        d = 32'h00000000;
        case (addr)
            REG_CTRL: d = {30'h0, s.ctrl};
            REG_STATUS: d = {24'h0, s.decClass, s.decIllegal, s.decValid};
            REG_COUNT: d = 32'(s.illegalCount);
            REG_LAST: d = s.lastInstr;
            default: d = 32'h00000000;
        endcase
        return d;
    endfunction

    logic       isBranch;
    logic       isXoForm;
    logic       isDForm;
    logic       isCompare;
    ifd_class_t cls;
    logic       accept;
    logic       addrPhase;
    logic [31:0] liExt;
    logic [31:0] bdExt;
    logic [31:0] offset;

    always_comb begin
        stateNext = stateReg;
        stateNext.hreadyout = 1'b1;
        stateNext.hresp = 1'b0;

        // bus address phase; only one slave, so hready is ours
        addrPhase = hsel && hready && htrans[1];
        stateNext.wrPend = addrPhase && hwrite;
        stateNext.wrAddr = haddr[7:0];
        if (addrPhase && !hwrite) begin
            stateNext.hrdata = readMux(stateReg, haddr[7:0]);
        end else begin
            stateNext.hrdata = 32'h00000000;
        end

        // bus data phase of a write; writes to read-only words are dropped
        if (stateReg.wrPend && stateReg.wrAddr == REG_CTRL) begin
            stateNext.ctrl = hwdata[1:0];
        end

        cls = classOf(instr);
        isBranch = (cls == CL_BRANCH) || (cls == CL_BCOND);
        isXoForm = (cls == CL_MULHU) || (cls == CL_MULLW) || (cls == CL_SUBFC) ||
                   (cls == CL_SUBFE) || (cls == CL_NEG) || (cls == CL_NABS);
        isCompare = (cls == CL_CMP) || (cls == CL_CMPL) || (cls == CL_CMPI) || (cls == CL_CMPLI);
        isDForm = (cls == CL_MULI) || (cls == CL_ORI) || (cls == CL_XORI) || (cls == CL_XORIS) ||
                  (cls == CL_SUBI) || (cls == CL_TWI) || (cls == CL_STB) || (cls == CL_STFD) ||
                  (cls == CL_STFDU) || (cls == CL_CMPI) || (cls == CL_CMPLI);

        liExt = {{6{instr[BOFF_LSB + 23]}}, instr[BOFF_LSB +: 24], 2'b00};
        bdExt = {{16{instr[CDISP_LSB + 13]}}, instr[CDISP_LSB +: 14], 2'b00};
        offset = (cls == CL_BRANCH) ? liExt : bdExt;

        // flush holds valid low while set; software clears it again
        accept = instrValid && stateReg.ctrl[CTRL_EN] && !stateReg.ctrl[CTRL_FLUSH];
        stateNext.decValid = accept;

        // field outputs refresh every cycle; consumers qualify them with decValid
        stateNext.decIllegal = accept && (cls == CL_ILLEGAL);
        stateNext.decClass = cls;
        stateNext.primaryOp = instr[PRIM_LSB +: 6];
        stateNext.extOp = instr[XEXT_LSB +: 10];
        stateNext.rtSel = instr[RT_LSB +: 5];
        stateNext.raSel = instr[RA_LSB +: 5];
        stateNext.rbSel = instr[RB_LSB +: 5];
        stateNext.dispExt = {{16{instr[15]}}, instr[15:0]};
        stateNext.absoluteTargetFlag = isBranch && instr[ABS_POS];
        if (instr[ABS_POS]) begin
            stateNext.branchTarget = offset;
        end else begin
            stateNext.branchTarget = instrAddr + offset;
        end
        stateNext.linkWrite = isBranch && instr[LINK_POS];
        stateNext.linkAddr = instrAddr + LINK_STEP;
        // branches reuse bit 31 as the link flag; D-forms carry no record bit
        stateNext.recordEn = !isBranch && !isDForm && !isCompare &&
                             (cls != CL_ILLEGAL) && instr[REC_POS];
        stateNext.ovEnable = isXoForm && instr[OE_POS];
        stateNext.compareTargetCrField = instr[CRF_LSB +: 3];
        stateNext.maskStartBit = instr[MSTART_LSB +: 5];
        stateNext.maskStopBit = instr[MSTOP_LSB +: 5];

        if (accept) begin
            stateNext.lastInstr = instr;
        end

        // a clearing write in the same cycle as a new illegal instruction leaves the count at one
        if (accept && cls == CL_ILLEGAL) begin
            if (stateReg.wrPend && stateReg.wrAddr == REG_COUNT) begin
                stateNext.illegalCount = COUNT_W'(1);
            end else begin
                stateNext.illegalCount = stateReg.illegalCount + COUNT_W'(1);
            end
        end else if (stateReg.wrPend && stateReg.wrAddr == REG_COUNT) begin
            stateNext.illegalCount = '0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= '0;
            stateReg.ctrl <= CTRL_RESET;
            stateReg.hreadyout <= 1'b1;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign decValid             = stateReg.decValid;
    assign decIllegal           = stateReg.decIllegal;
    assign decClass             = stateReg.decClass;
    assign primaryOp            = stateReg.primaryOp;
    assign extOp                = stateReg.extOp;
    assign rtSel                = stateReg.rtSel;
    assign raSel                = stateReg.raSel;
    assign rbSel                = stateReg.rbSel;
    assign dispExt              = stateReg.dispExt;
    assign branchTarget         = stateReg.branchTarget;
    assign absoluteTargetFlag   = stateReg.absoluteTargetFlag;
    assign linkWrite            = stateReg.linkWrite;
    assign linkAddr             = stateReg.linkAddr;
    assign recordEn             = stateReg.recordEn;
    assign ovEnable             = stateReg.ovEnable;
    assign compareTargetCrField = stateReg.compareTargetCrField;
    assign maskStartBit         = stateReg.maskStartBit;
    assign maskStopBit          = stateReg.maskStopBit;
    assign hreadyout            = stateReg.hreadyout;
    assign hresp                = stateReg.hresp;
    assign hrdata               = stateReg.hrdata;

endmodule

//--- test/ifd_decoder_sva.sv
module ifd_decoder_sva (
    input wire logic                 mclk,
    input wire logic                 reset_n,
    input wire logic                 instrValid,
    input wire logic [31:0]          instr,
    input wire logic [31:0]          instrAddr,
    input wire logic                 decValid,
    input wire logic                 decIllegal,
    input wire logic [5:0]           primaryOp,
    input wire logic [31:0]          dispExt,
    input wire logic [31:0]          branchTarget,
    input wire logic                 absoluteTargetFlag,
    input wire logic                 linkWrite,
    input wire logic [31:0]          linkAddr,
    input wire logic                 recordEn,
    input wire logic                 ovEnable,
    input wire logic [2:0]           compareTargetCrField,
    input wire logic [4:0]           maskStartBit,
    input wire logic [4:0]           maskStopBit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_PRIMARY: assert property (1'b1 |=> primaryOp == $past(instr[31:26]))
        else $error("primary opcode not from top six bits");
    AST_RECORD: assert property (instr[31:26] == 6'd31 && instr[10:1] == 10'd444 |=>
        recordEn == $past(instr[0]))
        else $error("record flag not passed for or");
    AST_BRANCH: assert property (instr[31:26] == 6'd18 |=> absoluteTargetFlag == $past(instr[1])
        && branchTarget == ($past(instr[1]) ? 32'h0 : $past(instrAddr))
        + {{6{$past(instr[25])}}, $past(instr[25:2]), 2'b00})
        else $error("branch target wrong");
    AST_LINK: assert property (instr[31:26] inside {6'd16, 6'd18} |=> linkWrite == $past(instr[0])
        && linkAddr == $past(instrAddr) + 32'h4)
        else $error("link request wrong");
    AST_DISP: assert property (1'b1 |=> dispExt == {{16{$past(instr[15])}}, $past(instr[15:0])})
        else $error("displacement not sign extended");
    AST_BCOND: assert property (instr[31:26] == 6'd16 && !instr[1] |=>
        branchTarget == $past(instrAddr) + {{16{$past(instr[15])}}, $past(instr[15:2]), 2'b00})
        else $error("conditional branch target wrong");
    AST_OVF: assert property (instr[31:26] == 6'h1f && instr[9:1] == 9'heb |=> ovEnable == $past(instr[10]))
        else $error("overflow enable not passed");
    AST_CRF: assert property (1'b1 |=> compareTargetCrField == $past(instr[25:23]))
        else $error("compare target field wrong");
    AST_MASK: assert property (instr[31:26] == 6'd21 |=> maskStartBit == $past(instr[10:6])
        && maskStopBit == $past(instr[5:1]))
        else $error("mask bounds wrong");
    AST_ILLEGAL: assert property (instrValid && instr[31:26] == 6'd63 |=> decIllegal == decValid)
        else $error("unknown opcode not flagged");
    AST_VALID: assert property (decValid || decIllegal |-> $past(instrValid) && decValid)
        else $error("valid without a word");
endmodule

bind ifd_decoder ifd_decoder_sva i_sva (.mclk, .reset_n, .instrValid, .instr, .instrAddr, .decValid, .decIllegal,
    .primaryOp, .dispExt, .branchTarget, .absoluteTargetFlag, .linkWrite, .linkAddr, .recordEn, .ovEnable,
    .compareTargetCrField, .maskStartBit, .maskStopBit);

//--- test/ifd_fetch_model.sv
module ifd_fetch_model (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        go,
    input  wire logic [31:0] word,
    input  wire logic [31:0] addr,
    input  wire logic        lenient,
    output logic             instrValid,
    output logic [31:0]      instr,
    output logic [31:0]      instrAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic isCmp;
    assign isCmp = word[31:26] inside {6'd10, 6'd11} || (word[31:26] == 6'd31 && word[10:1] inside {10'd0, 10'd32});
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            instrValid <= 1'b0;
            instr      <= 32'h0;
            instrAddr  <= 32'h0;
        end else if (go) begin
            instrValid <= 1'b1;
            instr      <= {word[31:23], word[22:21] & {2{lenient | ~isCmp}}, word[20:0]};
            instrAddr  <= addr;
        end else begin
            // idle lines keep moving so a stale word is never mistaken for a new one
            instrValid <= 1'b0;
            instr      <= ~instr;
            instrAddr  <= ~instrAddr;
        end
    end
endmodule

//--- test/instruction_field_decoder_test.sv
module instruction_field_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ifd_pkg::*;
    logic        mclk = 0, reset_n = 0, fGo = 0, lenient = 0, hsel = 0, hwrite = 0, eV, armed = 0;
    logic [31:0] fWord = 0, fAddr = 0, haddr = 0, hwdata = 0, lastW = 0, eW, eA, rd;
    logic [1:0]  htrans = 0, ctrlModel = 2'h1;
    logic [2:0]  hsize = 3'h2, compareTargetCrField;
    logic        instrValid, decValid, decIllegal, hreadyout, hresp, absoluteTargetFlag, linkWrite, recordEn, ovEnable;
    logic [31:0] instr, instrAddr, dispExt, branchTarget, linkAddr, hrdata;
    logic [4:0]  rtSel, raSel, rbSel, maskStartBit, maskStopBit;
    ifd_class_t  decClass, eCls;
    int          miscompares = 0, checksDone = 0, cycles = 0, expIll = 0;
    logic [5:0]  primaryOp, P [16] = '{3, 7, 8, 10, 11, 16, 18, 20, 21, 23, 24, 26, 27, 38, 54, 55};
    ifd_class_t  PC [16] = '{CL_TWI, CL_MULI, CL_SUBI, CL_CMPLI, CL_CMPI, CL_BCOND, CL_BRANCH, CL_RLIMI,
                             CL_RLINM, CL_RLNM, CL_ORI, CL_XORI, CL_XORIS, CL_STB, CL_STFD, CL_STFDU};
    logic [9:0]  extOp, X [12] = '{0, 4, 32, 150, 215, 247, 306, 316, 412, 444, 598, 759};
    ifd_class_t  XC [12] = '{CL_CMP, CL_TW, CL_CMPL, CL_STWC, CL_STBX, CL_STBUX, CL_TLBI, CL_XOR, CL_ORC,
                             CL_OR, CL_SYNC, CL_STFDUX};
    logic [8:0]  XT [6] = '{8, 11, 104, 136, 235, 488};
    ifd_class_t  XTC [6] = '{CL_SUBFC, CL_MULHU, CL_NEG, CL_SUBFE, CL_MULLW, CL_NABS};
    logic [31:0] K [6] = '{32'h48000001, 32'h4bfffffe, 32'h4000fffd, 32'h2c200000, 32'hfc000000, 32'h7c0007f7};

    ifd_fetch_model i_fetch (.mclk, .reset_n, .go(fGo), .word(fWord), .addr(fAddr), .lenient, .instrValid, .instr,
        .instrAddr);
    ifd_decoder #(.COUNT_W(16)) i_dut (.mclk, .reset_n, .instrValid, .instr, .instrAddr, .decValid, .decIllegal,
        .decClass, .primaryOp, .extOp, .rtSel, .raSel, .rbSel, .dispExt, .branchTarget, .absoluteTargetFlag,
        .linkWrite, .linkAddr, .recordEn, .ovEnable, .compareTargetCrField, .maskStartBit, .maskStopBit, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);

    function automatic ifd_class_t ecls(input logic [31:0] w);
        for (int i = 0; i < 16; i++)
            if (w[31:26] == P[i]) return PC[i];
        if (w[31:26] != 6'd31) return CL_ILLEGAL;
        // ten-bit match first: 759 shares its low nine bits with 247 in the ten-bit table
        for (int i = 0; i < 12; i++)
            if (w[10:1] == X[i]) return XC[i];
        for (int i = 0; i < 6; i++)
            if (w[9:1] == XT[i]) return XTC[i];
        return CL_ILLEGAL;
    endfunction
    function automatic bit cmpCls(input ifd_class_t c);
        return c inside {CL_CMP, CL_CMPL, CL_CMPI, CL_CMPLI};
    endfunction
    function automatic bit eIll(input logic [31:0] w);
        return ecls(w) == CL_ILLEGAL || (cmpCls(ecls(w)) && w[21]);
    endfunction
    function automatic logic [31:0] bOff(input logic [31:0] w);
        return w[31:26] == 6'd18 ? {{6{w[25]}}, w[25:2], 2'b00} : {{16{w[15]}}, w[15:2], 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t decode field got %h exp %h word %h", $time, got, exp, eW);
        end
    endtask
    task automatic chkReg(input logic [31:0] a, input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t register %h read %h exp %h", $time, a, got, exp);
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (wr && a == 32'h0) ctrlModel <= wd[1:0];
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chkReg(a, rd, exp);
    endtask
    task automatic send(input logic [31:0] w);
        @(posedge mclk);
        fGo <= 1'b1;
        fWord <= w;
        fAddr <= $urandom;
        if ($urandom % 4 == 0) begin
            @(posedge mclk);
            fGo <= 1'b0;
        end
    endtask
    task automatic idle;
        @(posedge mclk);
        fGo <= 1'b0;
        lenient <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic run(input int n);
        logic [31:0] w;
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            case ($urandom % 4)
                0: w[31:26] = P[$urandom % 16];
                1: w = {6'd31, w[25:11], X[$urandom % 12], w[0]};
                2: w = {6'd31, w[25:10], XT[$urandom % 6], w[0]};
                default: ;
            endcase
            send(w);
        end
        idle();
    endtask

    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    always @(posedge mclk) begin
        armed = reset_n;
        eW = instr;
        eA = instrAddr;
        eV = instrValid & ctrlModel[0] & ~ctrlModel[1];
        if (eV) lastW = instr;
        if (eV && eIll(instr)) expIll++;
    end
    always @(negedge mclk) if (armed) begin
        eCls = eIll(eW) ? CL_ILLEGAL : ecls(eW);
        chk(32'(decValid), 32'(eV));
        chk(32'(decIllegal), 32'(eV & eIll(eW)));
        chk(32'(decClass), 32'(eCls));
        chk(32'({hreadyout, hresp}), 32'h2);
        chk(32'(primaryOp), 32'(eW[31:26]));
        chk(32'({extOp, rtSel, raSel, rbSel}), 32'({eW[10:1], eW[25:11]}));
        chk(dispExt, {{16{eW[15]}}, eW[15:0]});
        chk(branchTarget, (eW[1] ? 32'h0 : eA) + bOff(eW));
        chk(32'(absoluteTargetFlag), 32'(eW[31:26] inside {6'd16, 6'd18} && eW[1]));
        chk(32'(linkWrite), 32'(eW[31:26] inside {6'd16, 6'd18} && eW[0]));
        chk(linkAddr, eA + 32'h4);
        chk(32'(recordEn), 32'(eCls != CL_ILLEGAL && !cmpCls(eCls) && eW[0]
            && (eW[31:26] == 6'd31 || eCls inside {CL_RLIMI, CL_RLINM, CL_RLNM})));
        chk(32'(ovEnable), 32'(eW[10] &&
            eCls inside {CL_MULHU, CL_MULLW, CL_SUBFC, CL_SUBFE, CL_NEG, CL_NABS}));
        chk(32'(compareTargetCrField), 32'(eW[25:23]));
        chk(32'({maskStartBit, maskStopBit}), 32'(eW[10:1]));
    end

    initial begin
        void'($urandom(32'hb3e2e171));
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rdchk(32'h0, 32'h1);
        rdchk(32'h4, 32'h0);
        rdchk(32'h8, 32'h0);
        rdchk(32'hc, 32'h0);
        rdchk(32'h10, 32'h0);
        // corner words go out unfiltered so a wide compare reaches the decoder
        lenient <= 1'b1;
        foreach (K[i]) send(K[i]);
        idle();
        run(400);
        rdchk(32'h8, 32'(expIll));
        rdchk(32'hc, lastW);
        xfer(32'hc, 1'b1, 32'h5a5a5a5a);
        rdchk(32'hc, lastW);
        xfer(32'h8, 1'b1, 32'h0);
        expIll = 0;
        rdchk(32'h8, 32'h0);
        xfer(32'h0, 1'b1, 32'h3);
        run(30);
        rdchk(32'h8, 32'h0);
        xfer(32'h0, 1'b1, 32'h0);
        run(30);
        rdchk(32'h0, 32'h0);
        xfer(32'h0, 1'b1, 32'h1);
        run(100);
        rdchk(32'h8, 32'(expIll));
        finish_test();
    end
endmodule
